/* File: logic/rcp_cfg.svh */
`ifndef RCP_CFG_SVH
`define RCP_CFG_SVH

// frequencies in 0.01 Hz steps
`define RCP_FREQ_MAX        16'h9c40
`define RCP_LEVEL_RST       16'h0bb8
`define RCP_BW_RST          16'h03e8
`define RCP_SELF_COOL_FREQ  16'h07d0
// dc link thresholds in volts
`define RCP_OV_LOW_CLASS    10'h190
`define RCP_OV_HIGH_CLASS   10'h334
`define RCP_LV_LOW_CLASS    10'h0b4
`define RCP_LV_HIGH_CLASS   10'h168
// currents in percent of rated
`define RCP_TH_1MIN_RST     8'h96
`define RCP_TH_1MIN_MIN     8'h32
`define RCP_TH_1MIN_MAX     8'hc8
`define RCP_TH_CONT_RST     8'h64
`define RCP_TH_CONT_MIN     8'h32
`define RCP_TH_CONT_MAX     8'h96
`define RCP_WARN_LVL_RST    8'h96
`define RCP_WARN_LVL_MIN    8'h1e
`define RCP_WARN_LVL_MAX    8'h96
`define RCP_TRIP_LVL_RST    8'hb4
`define RCP_TRIP_LVL_MIN    8'h1e
`define RCP_TRIP_LVL_MAX    8'hc8
// times in tenths of a second
`define RCP_WARN_TIME_RST   10'h064
`define RCP_WARN_TIME_MAX   10'h12c
`define RCP_TRIP_TIME_RST   10'h258
`define RCP_TRIP_TIME_MAX   10'h258
// thermal heat per percent-excess to trip in one minute, in ticks
`define RCP_TH_MINUTE_TICKS 10'h258
// other defaults
`define RCP_SEL_RST         5'h11
`define RCP_MASK_RST        3'h2
`define RCP_MASK_LV         0
`define RCP_MASK_TRIP       1
`define RCP_MASK_RESTART    2
// time base: one tick per 100 ms at 40 ns clock
`define RCP_CLK_NS          40
`define RCP_TICK_NS         100000000
`define RCP_TICK_CYC        (`RCP_TICK_NS / `RCP_CLK_NS)
`endif

/* File: logic/rcp_pkg.sv */
package rcp_pkg;
   // relay function selector codes
   typedef enum logic [4:0] {
      RLY_FREQ_MATCH   = 5'h00, RLY_LEVEL_MATCH = 5'h01, RLY_RUN_WINDOW = 5'h02,
      RLY_HYST         = 5'h03, RLY_HYST_INV    = 5'h04, RLY_OVERLOAD   = 5'h05,
      RLY_INV_OVERLOAD = 5'h06, RLY_STALL       = 5'h07, RLY_OVT        = 5'h08,
      RLY_LVT          = 5'h09, RLY_OVERHEAT    = 5'h0a, RLY_CMD_LOSS   = 5'h0b,
      RLY_RUN          = 5'h0c, RLY_STOP        = 5'h0d, RLY_CONST      = 5'h0e,
      RLY_SEARCH       = 5'h0f, RLY_WAIT_RUN    = 5'h10, RLY_FAULT      = 5'h11,
      RLY_FAN          = 5'h12, RLY_BRAKE       = 5'h13
   } rcp_relay_sel_t;
   // setting write targets
   typedef enum logic [3:0] {
      SET_LEVEL     = 4'h0, SET_BW        = 4'h1, SET_RELAY_SEL = 4'h2,
      SET_MASK      = 4'h3, SET_TH_EN     = 4'h4, SET_TH_1MIN   = 4'h5,
      SET_TH_CONT   = 4'h6, SET_COOL      = 4'h7, SET_WARN_LVL  = 4'h8,
      SET_WARN_TIME = 4'h9, SET_TRIP_EN   = 4'ha, SET_TRIP_LVL  = 4'hb,
      SET_TRIP_TIME = 4'hc
   } rcp_set_sel_t;
endpackage

/* File: logic/rcp_timer_if.sv */
`timescale 1ns/100ps
interface rcp_timer_if;
   logic       tick;  // time base pulse
   logic       run;   // condition being timed
   logic [9:0] limit; // ticks to reach
   logic       done;  // condition held long enough
   modport owner (output tick, output run, output limit, input done);
   modport timer (input tick, input run, input limit, output done);
endinterface

/* File: logic/rcp_hold_timer.sv */
`timescale 1ns/100ps
module rcp_hold_timer (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst_n,
   // timed condition
   rcp_timer_if.timer  tif
);
   logic [9:0] cnt_q, cnt_d; // ticks the condition has held
   logic       done_q, done_d;

   // count only while held; any drop restarts from zero
   always_comb begin
      cnt_d = cnt_q;
      if (!tif.run) begin
         cnt_d = 10'h000;
      end else if (tif.tick && cnt_q < tif.limit) begin
         cnt_d = cnt_q + 10'h001;
      end
      done_d = tif.run && (cnt_d >= tif.limit);
   end

   // registers only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q  <= 10'h000;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   assign tif.done = done_q;
endmodule

/* File: logic/rcp_top.sv */
`timescale 1ns/100ps
`include "rcp_cfg.svh"
module rcp_top #(
   parameter int TICK_CYCLES = `RCP_TICK_CYC // clocks per 100 ms tick
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // setting writes and fixed drive options
   input  wire logic        set_wr,
   input  wire logic [3:0]  set_addr,
   input  wire logic [15:0] set_data,
   input  wire logic [15:0] max_frequency,
   input  wire logic        fan_trip_action,
   input  wire logic        brake_enable,
   input  wire logic        volt_class_high,
   // drive measurements
   input  wire logic [15:0] preset_freq,
   input  wire logic [15:0] run_freq,
   input  wire logic        accel,
   input  wire logic        decel,
   input  wire logic [9:0]  dc_link_volts,
   input  wire logic [7:0]  motor_current,
   // drive status
   input  wire logic        run_cmd,
   input  wire logic        output_active,
   input  wire logic        wait_run,
   input  wire logic        heatsink_overheat,
   input  wire logic        cmd_loss_analog,
   input  wire logic        cmd_loss_comm,
   input  wire logic        other_trip,
   input  wire logic        restart_try,
   input  wire logic        fan_trip,
   input  wire logic        brake_signal,
   input  wire logic        trip_clear,
   // results
   output logic             relay_q,
   output logic             output_shutoff_q,
   output logic             ovt_trip_q,
   output logic             lvt_trip_q,
   output logic             thermal_trip_q,
   output logic             overload_trip_q,
   output logic             overload_warn_q,
   output logic             set_reject_q
);
   // settings
   logic [15:0] level_q, level_d;       // detection level
   logic [15:0] bw_q, bw_d;             // detection bandwidth
   logic [4:0]  rsel_q, rsel_d;         // relay function select
   logic [2:0]  mask_q, mask_d;         // fault output mask
   logic        th_en_q, th_en_d;       // thermal enable
   logic [7:0]  th_1min_q, th_1min_d;   // one-minute level
   logic [7:0]  th_cont_q, th_cont_d;   // continuous level
   logic        cool_q, cool_d;         // cooling type
   logic [7:0]  warn_lvl_q, warn_lvl_d;
   logic [9:0]  warn_time_q, warn_time_d;
   logic        trip_en_q, trip_en_d;
   logic [7:0]  trip_lvl_q, trip_lvl_d;
   logic [9:0]  trip_time_q, trip_time_d;
   logic        rej_d;
   // time base
   logic [21:0] tick_cnt_q, tick_cnt_d;
   logic        tick_q, tick_d;
   // protection state
   logic [17:0] heat_q, heat_d;         // thermal accumulator
   logic        hyst_q, hyst_d;         // frequency hysteresis state
   logic        ovt_d, lvt_d, th_trip_d, ol_trip_d, warn_d, relay_d, shut_d;
   // helpers
   logic [15:0] half_bw;
   logic [15:0] diff_set, diff_lvl;
   logic        fdt1, fdt2, fdt3;
   logic [17:0] heat_limit;
   logic        in_range;

   rcp_timer_if warn_tif ();
   rcp_timer_if trip_tif ();

   // magnitude of a difference without a sign bit
   function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      absdiff = (a >= b) ? (a - b) : (b - a);
   endfunction

   // setting writes with range checks; bad values leave the old one
   always_comb begin
      level_d     = level_q;
      bw_d        = bw_q;
      rsel_d      = rsel_q;
      mask_d      = mask_q;
      th_en_d     = th_en_q;
      th_1min_d   = th_1min_q;
      th_cont_d   = th_cont_q;
      cool_d      = cool_q;
      warn_lvl_d  = warn_lvl_q;
      warn_time_d = warn_time_q;
      trip_en_d   = trip_en_q;
      trip_lvl_d  = trip_lvl_q;
      trip_time_d = trip_time_q;
      in_range    = 1'b0;
      rej_d       = 1'b0;
      if (set_wr) begin
         unique case (rcp_pkg::rcp_set_sel_t'(set_addr))
            rcp_pkg::SET_LEVEL, rcp_pkg::SET_BW: begin
               // never above the span or the max frequency
               in_range = set_data <= `RCP_FREQ_MAX && set_data <= max_frequency;
               if (in_range && set_addr == rcp_pkg::SET_LEVEL) level_d = set_data;
               if (in_range && set_addr == rcp_pkg::SET_BW) bw_d = set_data;
            end
            rcp_pkg::SET_RELAY_SEL: begin
               in_range = set_data <= 16'h0013;
               if (in_range) rsel_d = set_data[4:0];
            end
            rcp_pkg::SET_MASK: begin
               in_range = set_data <= 16'h0007;
               if (in_range) mask_d = set_data[2:0];
            end
            rcp_pkg::SET_TH_EN: begin
               in_range = set_data <= 16'h0001;
               if (in_range) th_en_d = set_data[0];
            end
            rcp_pkg::SET_TH_1MIN: begin
               // one-minute level may not drop below continuous
               in_range = set_data >= 16'(`RCP_TH_1MIN_MIN) && set_data <= 16'(`RCP_TH_1MIN_MAX)
                          && set_data >= 16'(th_cont_q);
               if (in_range) th_1min_d = set_data[7:0];
            end
            rcp_pkg::SET_TH_CONT: begin
               in_range = set_data >= 16'(`RCP_TH_CONT_MIN) && set_data <= 16'(`RCP_TH_CONT_MAX)
                          && set_data <= 16'(th_1min_q);
               if (in_range) th_cont_d = set_data[7:0];
            end
            rcp_pkg::SET_COOL: begin
               in_range = set_data <= 16'h0001;
               if (in_range) cool_d = set_data[0];
            end
            rcp_pkg::SET_WARN_LVL: begin
               in_range = set_data >= 16'(`RCP_WARN_LVL_MIN)
                          && set_data <= 16'(`RCP_WARN_LVL_MAX);
               if (in_range) warn_lvl_d = set_data[7:0];
            end
            rcp_pkg::SET_WARN_TIME: begin
               in_range = set_data <= 16'(`RCP_WARN_TIME_MAX);
               if (in_range) warn_time_d = set_data[9:0];
            end
            rcp_pkg::SET_TRIP_EN: begin
               in_range = set_data <= 16'h0001;
               if (in_range) trip_en_d = set_data[0];
            end
            rcp_pkg::SET_TRIP_LVL: begin
               in_range = set_data >= 16'(`RCP_TRIP_LVL_MIN) && set_data <= 16'(`RCP_TRIP_LVL_MAX);
               if (in_range) trip_lvl_d = set_data[7:0];
            end
            rcp_pkg::SET_TRIP_TIME: begin
               in_range = set_data <= 16'(`RCP_TRIP_TIME_MAX);
               if (in_range) trip_time_d = set_data[9:0];
            end
            default: in_range = 1'b0; // codes 13..15 unused
         endcase
         rej_d = !in_range;
      end
   end

   // time base; a shorter TICK_CYCLES speeds up simulation
   always_comb begin
      tick_d     = (tick_cnt_q == 22'(TICK_CYCLES - 1));
      tick_cnt_d = tick_d ? 22'h000000 : tick_cnt_q + 22'h000001;
   end

   // frequency detection terms
   always_comb begin
      half_bw  = bw_q >> 1;
      diff_set = absdiff(preset_freq, run_freq);
      diff_lvl = absdiff(level_q, run_freq);
      fdt1     = diff_set <= half_bw;
      fdt2     = (preset_freq == level_q) && fdt1;
      fdt3     = diff_lvl <= half_bw;
      // hysteresis: on at level while rising, off at or below level-bw/2 falling
      hyst_d   = hyst_q;
      if (accel) begin
         hyst_d = run_freq >= level_q;
      end else if (decel) begin
         hyst_d = {1'b0, run_freq} + {1'b0, half_bw} > {1'b0, level_q};
      end
   end

   // thermal model, trips and warning
   always_comb begin
      // heat for (one-minute minus continuous) excess over one minute
      heat_limit = 18'(th_1min_q - th_cont_q) * 18'(`RCP_TH_MINUTE_TICKS);
      heat_d     = heat_q;
      if (!th_en_q) begin
         heat_d = 18'h00000;
      end else if (tick_q) begin
         if (motor_current > th_cont_q) begin
            // larger excess heats faster, so trip comes sooner
            heat_d = heat_q + 18'(motor_current - th_cont_q);
            if (heat_d > heat_limit) heat_d = heat_limit;
         end else begin
            // shaft fan cools poorly at low speed: half the cooling rate
            if (!cool_q && run_freq < `RCP_SELF_COOL_FREQ) begin
               heat_d = heat_q - ((18'(th_cont_q - motor_current) >> 1) > heat_q ? heat_q
                        : (18'(th_cont_q - motor_current) >> 1));
            end else begin
               heat_d = heat_q - (18'(th_cont_q - motor_current) > heat_q ? heat_q
                        : 18'(th_cont_q - motor_current));
            end
         end
      end
      // trips hold until cleared; a new cause wins over a clear
      ovt_d     = (dc_link_volts > (volt_class_high ? `RCP_OV_HIGH_CLASS : `RCP_OV_LOW_CLASS))
                  || (ovt_trip_q && !trip_clear);
      lvt_d     = (dc_link_volts < (volt_class_high ? `RCP_LV_HIGH_CLASS : `RCP_LV_LOW_CLASS))
                  || (lvt_trip_q && !trip_clear);
      th_trip_d = (th_en_q && motor_current > th_1min_q && heat_q >= heat_limit)
                  || (thermal_trip_q && !trip_clear);
      ol_trip_d = (trip_en_q && trip_tif.done) || (overload_trip_q && !trip_clear);
      warn_d    = warn_tif.done;
      shut_d    = ovt_d || lvt_d || th_trip_d || ol_trip_d;
   end

   // timed overload conditions
   assign warn_tif.tick  = tick_q;
   assign warn_tif.run   = motor_current > warn_lvl_q;
   assign warn_tif.limit = warn_time_q;
   assign trip_tif.tick  = tick_q;
   assign trip_tif.run   = trip_en_q && motor_current >= trip_lvl_q;
   assign trip_tif.limit = trip_time_q;

   rcp_hold_timer u_warn (
      .clk   (clk),
      .rst_n (rst_n),
      .tif   (warn_tif.timer)
   );

   rcp_hold_timer u_trip (
      .clk   (clk),
      .rst_n (rst_n),
      .tif   (trip_tif.timer)
   );

   // relay selection; unsupported codes drive the relay off
   always_comb begin
      relay_d = 1'b0;
      unique case (rcp_pkg::rcp_relay_sel_t'(rsel_q))
         rcp_pkg::RLY_FREQ_MATCH:  relay_d = fdt1;
         rcp_pkg::RLY_LEVEL_MATCH: relay_d = fdt2;
         rcp_pkg::RLY_RUN_WINDOW:  relay_d = fdt3;
         rcp_pkg::RLY_HYST:        relay_d = hyst_d;
         rcp_pkg::RLY_HYST_INV:    relay_d = !hyst_d;
         rcp_pkg::RLY_OVERLOAD:    relay_d = warn_d;
         rcp_pkg::RLY_OVT:         relay_d = ovt_d;
         rcp_pkg::RLY_LVT:         relay_d = lvt_d;
         rcp_pkg::RLY_OVERHEAT:    relay_d = heatsink_overheat;
         rcp_pkg::RLY_CMD_LOSS:    relay_d = cmd_loss_analog || cmd_loss_comm;
         rcp_pkg::RLY_RUN:         relay_d = run_cmd && output_active;
         rcp_pkg::RLY_STOP:        relay_d = !output_active && !run_cmd;
         rcp_pkg::RLY_CONST:       relay_d = output_active && !accel && !decel;
         rcp_pkg::RLY_WAIT_RUN:    relay_d = wait_run && !run_cmd && !shut_d && !other_trip;
         rcp_pkg::RLY_FAULT: begin
            // each enabled event class asserts the relay
            relay_d = (mask_q[`RCP_MASK_LV] && lvt_d)
                      || (mask_q[`RCP_MASK_TRIP] && (ovt_d || th_trip_d || ol_trip_d || other_trip))
                      || (mask_q[`RCP_MASK_RESTART] && restart_try);
         end
         rcp_pkg::RLY_FAN:         relay_d = fan_trip && !fan_trip_action;
         rcp_pkg::RLY_BRAKE:       relay_d = brake_enable && brake_signal;
         default:                  relay_d = 1'b0; // stall, search, inverter overload
      endcase
   end

   // registers only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         level_q          <= `RCP_LEVEL_RST;
         bw_q             <= `RCP_BW_RST;
         rsel_q           <= `RCP_SEL_RST;
         mask_q           <= `RCP_MASK_RST;
         th_en_q          <= 1'b0;
         th_1min_q        <= `RCP_TH_1MIN_RST;
         th_cont_q        <= `RCP_TH_CONT_RST;
         cool_q           <= 1'b0;
         warn_lvl_q       <= `RCP_WARN_LVL_RST;
         warn_time_q      <= `RCP_WARN_TIME_RST;
         trip_en_q        <= 1'b1;
         trip_lvl_q       <= `RCP_TRIP_LVL_RST;
         trip_time_q      <= `RCP_TRIP_TIME_RST;
         tick_cnt_q       <= 22'h000000;
         tick_q           <= 1'b0;
         heat_q           <= 18'h00000;
         hyst_q           <= 1'b0;
         relay_q          <= 1'b0;
         output_shutoff_q <= 1'b0;
         ovt_trip_q       <= 1'b0;
         lvt_trip_q       <= 1'b0;
         thermal_trip_q   <= 1'b0;
         overload_trip_q  <= 1'b0;
         overload_warn_q  <= 1'b0;
         set_reject_q     <= 1'b0;
      end else begin
         level_q          <= level_d;
         bw_q             <= bw_d;
         rsel_q           <= rsel_d;
         mask_q           <= mask_d;
         th_en_q          <= th_en_d;
         th_1min_q        <= th_1min_d;
         th_cont_q        <= th_cont_d;
         cool_q           <= cool_d;
         warn_lvl_q       <= warn_lvl_d;
         warn_time_q      <= warn_time_d;
         trip_en_q        <= trip_en_d;
         trip_lvl_q       <= trip_lvl_d;
         trip_time_q      <= trip_time_d;
         tick_cnt_q       <= tick_cnt_d;
         tick_q           <= tick_d;
         heat_q           <= heat_d;
         hyst_q           <= hyst_d;
         relay_q          <= relay_d;
         output_shutoff_q <= shut_d;
         ovt_trip_q       <= ovt_d;
         lvt_trip_q       <= lvt_d;
         thermal_trip_q   <= th_trip_d;
         overload_trip_q  <= ol_trip_d;
         overload_warn_q  <= warn_d;
         set_reject_q     <= rej_d;
      end
   end
endmodule

/* File: sim/rcp_top_sva.sv */
`timescale 1ns/100ps
`include "rcp_cfg.svh"
module rcp_top_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // settings and supply
   input wire logic        set_wr,
   input wire logic [3:0]  set_addr,
   input wire logic [15:0] set_data,
   input wire logic [15:0] max_frequency,
   input wire logic        volt_class_high,
   input wire logic [9:0]  dc_link_volts,
   input wire logic        trip_clear,
   // results
   input wire logic        ovt_trip_q,
   input wire logic        lvt_trip_q,
   input wire logic        thermal_trip_q,
   input wire logic        overload_trip_q,
   input wire logic        output_shutoff_q,
   input wire logic        overload_warn_q,
   input wire logic        set_reject_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // class thresholds picked live, the class pin may move at any time
   wire logic [9:0] ov_lim = volt_class_high ? `RCP_OV_HIGH_CLASS : `RCP_OV_LOW_CLASS;
   wire logic [9:0] lv_lim = volt_class_high ? `RCP_LV_HIGH_CLASS : `RCP_LV_LOW_CLASS;
   // any latched trip
   wire logic       any_t  = ovt_trip_q | lvt_trip_q | thermal_trip_q | overload_trip_q;
   AST_OVT_SET: assert property (dc_link_volts > ov_lim |=> ovt_trip_q)
      else $error("over-voltage trip not raised");
   AST_LVT_SET: assert property (dc_link_volts < lv_lim |=> lvt_trip_q)
      else $error("low-voltage trip not raised");
   AST_LVT_HOLD: assert property (lvt_trip_q && !trip_clear |=> lvt_trip_q)
      else $error("low-voltage trip dropped without clear");
   AST_SHUT_ON: assert property (any_t |-> ##[0:1] output_shutoff_q)
      else $error("trip without output shutoff");
   AST_SHUT_OFF: assert property (!any_t && !$past(any_t) |-> !output_shutoff_q)
      else $error("shutoff without trip");
   AST_REJ_ADDR: assert property (set_wr && set_addr > 4'hc |=> set_reject_q)
      else $error("unknown setting accepted");
   AST_REJ_SEL: assert property (set_wr && set_addr == 4'h2 && set_data > 16'h0013
      |=> set_reject_q)
      else $error("relay select out of range accepted");
   AST_REJ_FREQ: assert property (set_wr && set_addr <= 4'h1 && set_data > max_frequency
      |=> set_reject_q)
      else $error("frequency setting above max accepted");
   AST_REJ_PULSE: assert property (!set_wr |=> !set_reject_q)
      else $error("reject without write");
   // main scenarios reached
   cover property (ovt_trip_q);
   cover property (overload_warn_q);
   cover property (thermal_trip_q);
   cover property (set_reject_q);
endmodule
bind rcp_top rcp_top_sva rcp_top_sva_inst (.clk(clk), .rst_n(rst_n), .set_wr(set_wr),
   .set_addr(set_addr), .set_data(set_data), .max_frequency(max_frequency),
   .volt_class_high(volt_class_high), .dc_link_volts(dc_link_volts), .trip_clear(trip_clear),
   .ovt_trip_q(ovt_trip_q), .lvt_trip_q(lvt_trip_q), .thermal_trip_q(thermal_trip_q),
   .overload_trip_q(overload_trip_q), .output_shutoff_q(output_shutoff_q),
   .overload_warn_q(overload_warn_q), .set_reject_q(set_reject_q));

/* File: sim/rcp_relay_load.sv */
`timescale 1ns/100ps
module rcp_relay_load (
   // clock
   input wire logic clk,
   // coil drive
   input wire logic relay_q,
   // contact seen by the control gear
   output logic     contact
);
   // armature lags the coil by a clock, so never faster than the drive
   always_ff @(posedge clk) contact <= relay_q;
endmodule

/* File: sim/tb_rcp_top.sv */
`timescale 1ns/100ps
module tb_rcp_top;
   // stimulus, all quiet at time zero
   logic clk = 1'b0, rst_n = 1'b0, set_wr = 1'b0, trip_clear = 1'b0, volt_class_high = 1'b0;
   logic run_cmd = 0, output_active = 0, wait_run = 0, heatsink_overheat = 0, cmd_loss_analog = 0;
   logic cmd_loss_comm = 0, other_trip = 0, restart_try = 0, fan_trip = 0, brake_signal = 0;
   logic fan_trip_action = 0, brake_enable = 0, accel = 0, decel = 0;
   logic [3:0]  set_addr = 4'h0;
   logic [15:0] set_data = 16'h0000, max_frequency = 16'h1770;
   logic [15:0] preset_freq = 16'h0000, run_freq = 16'h0000;
   logic [9:0]  dc_link_volts = 10'h12c;
   logic [7:0]  motor_current = 8'h0a;
   // results
   logic relay_q, output_shutoff_q, ovt_trip_q, lvt_trip_q, thermal_trip_q;
   logic overload_trip_q, overload_warn_q, set_reject_q, contact;
   // bench state
   int failures = 0, compares = 0, cyc = 0, sel, i, n, thr;
   bit [31:0] seed = 36, r;
   bit [2:0]  mask;
   bit        hyst = 1'b0;
   int sels [14] = '{0, 1, 2, 3, 4, 10, 11, 12, 13, 14, 16, 17, 18, 19};
   rcp_top #(.TICK_CYCLES(4)) rcp_top_inst (.clk(clk), .rst_n(rst_n), .set_wr(set_wr),
      .set_addr(set_addr), .set_data(set_data), .max_frequency(max_frequency),
      .fan_trip_action(fan_trip_action), .brake_enable(brake_enable),
      .volt_class_high(volt_class_high), .preset_freq(preset_freq), .run_freq(run_freq),
      .accel(accel), .decel(decel), .dc_link_volts(dc_link_volts),
      .motor_current(motor_current), .run_cmd(run_cmd), .output_active(output_active),
      .wait_run(wait_run), .heatsink_overheat(heatsink_overheat),
      .cmd_loss_analog(cmd_loss_analog), .cmd_loss_comm(cmd_loss_comm),
      .other_trip(other_trip), .restart_try(restart_try), .fan_trip(fan_trip),
      .brake_signal(brake_signal), .trip_clear(trip_clear), .relay_q(relay_q),
      .output_shutoff_q(output_shutoff_q), .ovt_trip_q(ovt_trip_q), .lvt_trip_q(lvt_trip_q),
      .thermal_trip_q(thermal_trip_q), .overload_trip_q(overload_trip_q),
      .overload_warn_q(overload_warn_q), .set_reject_q(set_reject_q));
   rcp_relay_load rcp_relay_load_inst (.clk(clk), .relay_q(relay_q), .contact(contact));
   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end
   // hang guard, well above the longest path
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         failures++;
         end_sim();
      end
   end
   // verdict
   task end_sim;
      if (failures == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // inputs move a fixed 2 ns after each edge
   task cycle;
      @(posedge clk);
      #2;
   endtask
   // one-bit result compare
   task chk(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // setting write, reject seen one cycle later
   task wr(input logic [3:0] a, input logic [15:0] d, input logic rej);
      set_wr = 1'b1;
      set_addr = a;
      set_data = d;
      cycle();
      chk(set_reject_q, rej);
      set_wr = 1'b0;
      cycle();
   endtask
   // bounded wait for a flag
   task automatic waitf(ref logic s, output int k);
      k = 0;
      while (s !== 1'b1 && k < 2000) begin
         cycle();
         k++;
      end
   endtask
   function automatic bit [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // relay model, level 30.00 Hz and half band 5.00 Hz
   function automatic logic mdl(int s);
      int df, dl;
      df = int'(preset_freq) - int'(run_freq);
      dl = 3000 - int'(run_freq);
      if (df < 0) df = -df;
      if (dl < 0) dl = -dl;
      case (s)
         0: return df <= 500;
         1: return preset_freq == 16'h0bb8 && df <= 500;
         2: return dl <= 500;
         3: return hyst;
         4: return !hyst;
         10: return heatsink_overheat;
         11: return cmd_loss_analog | cmd_loss_comm;
         12: return run_cmd & output_active;
         13: return !output_active & !run_cmd;
         14: return output_active & !accel & !decel;
         16: return wait_run & !run_cmd & !other_trip;
         17: return (mask[1] & other_trip) | (mask[2] & restart_try);
         18: return fan_trip & !fan_trip_action;
         default: return brake_signal & brake_enable;
      endcase
   endfunction
   // main sequence
   initial begin
      repeat (12) cycle();
      rst_n = 1'b1;
      other_trip = 1'b1;
      cycle();
      cycle();
      chk(relay_q, 1'b1);
      other_trip = 1'b0;
      restart_try = 1'b1;
      cycle();
      cycle();
      chk(relay_q, 1'b0);
      wr(4'hd, 16'h0000, 1'b1);
      wr(4'h2, 16'h0014, 1'b1);
      wr(4'h0, 16'h1771, 1'b1);
      wr(4'h1, 16'h1770, 1'b0);
      wr(4'h1, 16'h03e8, 1'b0);
      foreach (sels[j]) begin
         sel = sels[j];
         mask = 3'(xs());
         wr(4'h3, 16'(mask), 1'b0);
         wr(4'h2, 16'(sel), 1'b0);
         repeat (8) begin
            r = xs();
            preset_freq = r[12] ? 16'h0bb8 : 16'(2000 + r % 2000);
            run_freq = 16'(2000 + (r >> 13) % 2000);
            accel = r[0];
            decel = !r[0] & r[1];
            {run_cmd, output_active, wait_run, heatsink_overheat, cmd_loss_analog,
             cmd_loss_comm, other_trip, restart_try, fan_trip, brake_signal,
             fan_trip_action, brake_enable} = r[27:16];
            if (accel) hyst = run_freq >= 16'h0bb8;
            else if (decel) hyst = run_freq > 16'h09c4;
            cycle();
            chk(relay_q, mdl(sel));
         end
      end
      other_trip = 1'b0;
      for (i = 0; i < 4; i++) begin
         volt_class_high = i[0];
         thr = i[1] ? (i[0] ? 820 : 400) : (i[0] ? 360 : 180);
         dc_link_volts = i[0] ? 10'h258 : 10'h12c;
         trip_clear = 1'b1;
         cycle();
         trip_clear = 1'b0;
         wr(4'h2, i[1] ? 16'h0008 : 16'h0009, 1'b0);
         dc_link_volts = 10'(thr);
         cycle();
         chk(i[1] ? ovt_trip_q : lvt_trip_q, 1'b0);
         dc_link_volts = i[1] ? 10'(thr + 1) : 10'(thr - 1);
         cycle();
         cycle();
         dc_link_volts = i[0] ? 10'h258 : 10'h12c;
         cycle();
         chk(i[1] ? ovt_trip_q : lvt_trip_q, 1'b1);
         chk(relay_q, 1'b1);
         chk(contact, 1'b1);
      end
      volt_class_high = 1'b0;
      dc_link_volts = 10'h12c;
      trip_clear = 1'b1;
      cycle();
      trip_clear = 1'b0;
      wr(4'h2, 16'h0005, 1'b0);
      wr(4'h8, 16'h0064, 1'b0);
      wr(4'h9, 16'h0003, 1'b0);
      wr(4'hb, 16'h0082, 1'b0);
      wr(4'hc, 16'h0005, 1'b0);
      motor_current = 8'h78;
      waitf(overload_warn_q, n);
      chk(overload_warn_q, 1'b1);
      chk(logic'(n >= 8), 1'b1);
      cycle();
      chk(relay_q, 1'b1);
      motor_current = 8'h5a;
      cycle();
      cycle();
      chk(overload_warn_q, 1'b0);
      motor_current = 8'h8c;
      waitf(overload_trip_q, n);
      chk(logic'(n >= 16), 1'b1);
      motor_current = 8'h32;
      cycle();
      cycle();
      chk(overload_trip_q, 1'b1);
      chk(output_shutoff_q, 1'b1);
      wr(4'ha, 16'h0000, 1'b0);
      trip_clear = 1'b1;
      cycle();
      trip_clear = 1'b0;
      wr(4'h5, 16'h005a, 1'b1);
      wr(4'h6, 16'h00a0, 1'b1);
      wr(4'h7, 16'h0001, 1'b0);
      motor_current = 8'hc8;
      repeat (1400) cycle();
      chk(thermal_trip_q, 1'b0);
      wr(4'h4, 16'h0001, 1'b0);
      waitf(thermal_trip_q, n);
      chk(thermal_trip_q, 1'b1);
      end_sim();
   end
endmodule
